// file: hw/ppal_core.sv
// Position preset and access level command interpreter
`timescale 1ns/10ps
module ppal_core (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Parameter channel request
  input wire logic reqValid,
  input wire ppal_pkg::ppal_req_s req,
  // Parameter channel answer
  output logic transferReleaseFlag,
  output ppal_pkg::ppal_resp_s resp_q,
  // Encoder side
  input wire logic encoderReset,
  input wire logic [39:0] rawPosition,
  input wire logic [39:0] measureRangeMax,
  output logic [39:0] position_q,
  output logic [2:0] accessLevel_q,
  output logic presetPending_q
);

  // ****************************************
  // Decoding helpers
  // ****************************************

  // Key stored for a level; level 0 matches any key
  function automatic logic keyMatches(input logic [2:0] lvl, input logic [31:0] key);
    logic ok;
    ok = 1'b0;
    unique case (lvl)
      3'h0: ok = 1'b1;
      3'h1: ok = (key == ppal_pkg::KEY_L1);
      3'h2: ok = (key == ppal_pkg::KEY_L2);
      3'h3: ok = (key == ppal_pkg::KEY_L3);
      3'h4: ok = (key == ppal_pkg::KEY_L4);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Defining value of a resource at a direct read offset
  function automatic logic [7:0] defValue(input logic isPreset, input logic [15:0] off);
    logic [7:0] v;
    v = 8'h00;
    if (off == ppal_pkg::DEF_SIZE) begin
      v = ppal_pkg::DATA_SIZE;
    end else if (off == ppal_pkg::DEF_RD_LEVEL) begin
      v = isPreset ? ppal_pkg::PRESET_RD_LEVEL : ppal_pkg::ACCESS_RD_LEVEL;
    end else if (off == ppal_pkg::DEF_WR_LEVEL) begin
      v = isPreset ? ppal_pkg::PRESET_WR_LEVEL : ppal_pkg::ACCESS_WR_LEVEL;
    end else if (off == ppal_pkg::DEF_OVERRUN) begin
      v = isPreset ? ppal_pkg::PRESET_OVERRUN : ppal_pkg::ACCESS_OVERRUN;
    end
    return v;
  endfunction

  // Present level against the level a resource asks for
  function automatic logic levelSuffices(input logic [2:0] have, input logic [7:0] need);
    logic ok;
    ok = ({5'h00, have} >= need);
    return ok;
  endfunction

  // ****************************************
  // Request decode
  // ****************************************
  logic hitPreset;
  logic hitAccess;
  logic isRead;
  logic isWrite;
  logic isDirect;
  logic [39:0] presetValue;
  logic [2:0] reqLevel;
  logic [31:0] reqKey;
  logic presetInRange;
  logic presetAllowed;
  logic levelAccepted;
  logic [39:0] newOffset;
  logic levelInRange;
  logic presetRdOk;
  logic accessRdOk;
  logic accessWrOk;
  logic presetTaken;
  logic levelTaken;

  // Classify the transaction and pick out its fields
  assign hitPreset = (req.resIndex == ppal_pkg::RES_PRESET); // see RQ1
  assign hitAccess = (req.resIndex == ppal_pkg::RES_ACCESS); // see RQ8
  assign isRead = reqValid && (req.kind == ppal_pkg::KIND_READ);
  assign isWrite = reqValid && (req.kind == ppal_pkg::KIND_WRITE);
  assign isDirect = reqValid && (req.kind == ppal_pkg::KIND_DIRECT);
  assign presetValue = req.data[ppal_pkg::POS_W-1:0]; // see RQ3
  assign reqLevel = req.data[ppal_pkg::LEVEL_W-1:0]; // see RQ12
  assign reqKey = req.data[63:ppal_pkg::KEY_LSB]; // see RQ12

  // Level gates for each resource and direction
  assign presetRdOk = levelSuffices(accessLevel_q, ppal_pkg::PRESET_RD_LEVEL); // see RQ1
  assign accessRdOk = levelSuffices(accessLevel_q, ppal_pkg::ACCESS_RD_LEVEL); // see RQ8
  assign accessWrOk = levelSuffices(accessLevel_q, ppal_pkg::ACCESS_WR_LEVEL); // see RQ8

  // Preset checks: range and write level
  assign presetInRange = (presetValue <= measureRangeMax); // see RQ4
  assign presetAllowed = presetInRange && levelSuffices(accessLevel_q, ppal_pkg::PRESET_WR_LEVEL); // see RQ1

  // Level request needs a level in range and its key
  assign levelInRange = (req.data[7:0] <= {5'h00, ppal_pkg::LEVEL_MAX}); // see RQ12
  assign levelAccepted = levelInRange && accessWrOk && keyMatches(reqLevel, reqKey); // see RQ10 see RQ11 see RQ18

  // Offset that maps the present shaft position to the sent value
  // Wraps modulo 2^40 when the preset lies below the raw position; the later sum undoes it
  assign newOffset = presetValue - rawPosition; // see RQ2

  // ****************************************
  // Write gating
  // ****************************************

  // Writes that change state; an encoder reset in the same cycle beats a level write
  assign levelTaken = isWrite && hitAccess && levelAccepted && !encoderReset; // see RQ10
  assign presetTaken = isWrite && hitPreset && presetAllowed; // see RQ2

  // ****************************************
  // Access level
  // ****************************************

  // Public level after reset or encoder reset, held until a matching request
  always_ff @(posedge ref_clk) begin
    if (!nrst || encoderReset) begin
      accessLevel_q <= ppal_pkg::LEVEL_PUBLIC; // see RQ9
    end else if (levelTaken) begin
      accessLevel_q <= reqLevel; // see RQ10
    end
  end

  // ****************************************
  // Position preset
  // ****************************************
  logic [39:0] pendingOffset_q;
  logic [39:0] activeOffset_q;

  // Accepted preset waits here until the encoder reset
  // A new preset beats a same-cycle encoder reset, so it is never lost after a clean answer
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pendingOffset_q <= 40'h00_0000_0000;
      presetPending_q <= 1'b0;
    end else if (presetTaken) begin
      pendingOffset_q <= newOffset; // see RQ2
      presetPending_q <= 1'b1;
    end else if (encoderReset) begin
      presetPending_q <= 1'b0; // see RQ6
    end
  end

  // The encoder reset puts the waiting offset into use
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      activeOffset_q <= 40'h00_0000_0000;
    end else if (encoderReset && presetPending_q) begin
      activeOffset_q <= pendingOffset_q; // see RQ6
    end
  end

  // Reported position is raw position plus offset in use
  // No motion sync here: the shaft must stand still while a preset is made
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      position_q <= 40'h00_0000_0000;
    end else begin
      position_q <= rawPosition + activeOffset_q; // see RQ2
    end
  end

  // ****************************************
  // Answer
  // ****************************************
  ppal_pkg::ppal_resp_s resp_d;

  // Build the answer for this cycle's request
  always_comb begin
    resp_d = '0;
    if (isDirect && (hitPreset || hitAccess)) begin
      resp_d.data = {56'h00_0000_0000_0000, defValue(hitPreset, req.offset)}; // see RQ1 see RQ8
    end else if (isRead && hitPreset) begin
      // Offset in use, so a waiting preset stays hidden until the encoder reset
      resp_d.data = {24'h00_0000, activeOffset_q}; // see RQ5
      resp_d.refused = !presetRdOk; // see RQ1
    end else if (isRead && hitAccess) begin
      resp_d.data = {61'h0, accessLevel_q}; // see RQ13
      resp_d.refused = !accessRdOk; // see RQ8
    end else if (isWrite && hitPreset) begin
      resp_d.refused = !presetTaken; // see RQ4
    end else if (isWrite && hitAccess) begin
      resp_d.refused = !levelTaken; // see RQ18
    end else begin
      resp_d.refused = 1'b1;
    end
  end

  // Answer is registered and holds until the next request
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      resp_q <= '0;
    end else if (reqValid) begin
      resp_q <= resp_d;
    end
  end

  // ****************************************
  // Release flag
  // ****************************************

  // Release flag pulses one cycle after each request
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      transferReleaseFlag <= 1'b0;
    end else begin
      transferReleaseFlag <= reqValid;
    end
  end

endmodule

// file: pkg/ppal_pkg.sv
// Constants and types for the position preset and access level handler
// Summary of operation
// RQ1 - Position preset resource: index 101h, 8 bytes, read level 0, write level 2, overrun 100.
// RQ2 - A preset write makes the sent value the position of the present shaft position.
// RQ3 - Preset is unsigned 40 bit, bytes 4 to 0, right justified.
// RQ4 - A preset is valid only inside the measurement range.
// RQ5 - A preset read returns the offset in use, same 40-bit format.
// RQ6 - Master commands an encoder reset after a preset; preset acts only then.
// RQ7 - Master presets only with the shaft at rest; no motion sync here.
// RQ8 - Access level resource: index 104h, 8 bytes, read and write level 0, overrun 70.
// RQ9 - After power-up and every reset the access level is 0.
// RQ10 - Level changes only with its matching key and holds until set again.
// RQ11 - Level 0 needs no key; keys for 1 to 4 are bytes 31h to 34h repeated.
// RQ12 - Level request: key in bytes 7 to 4, level 0 to 4 in byte 0.
// RQ13 - A level read returns the active level in byte 0.
// RQ14 - Master uses no nonzero offset on the access level resource; the master model zeroes it except on direct reads, which keep theirs.
// RQ15 - Master sets a level with level, key, address 1D 04, zero offset, control 01.
// RQ16 - Master reads the level with address 55 04, then waits for release and reads byte 0.
// RQ17 - Master writes a preset with five bytes, zeros above, low address 01, control 01.
// RQ18 - A wrong key leaves the access level unchanged.
package ppal_pkg;

  // ****************************************
  // Resource indices and defining values
  // ****************************************
  localparam logic [9:0] RES_PRESET = 10'h101;
  localparam logic [9:0] RES_ACCESS = 10'h104;
  localparam logic [7:0] DATA_SIZE = 8'h08;
  localparam logic [7:0] PRESET_RD_LEVEL = 8'h00;
  localparam logic [7:0] PRESET_WR_LEVEL = 8'h02;
  localparam logic [7:0] PRESET_OVERRUN = 8'h64;
  localparam logic [7:0] ACCESS_RD_LEVEL = 8'h00;
  localparam logic [7:0] ACCESS_WR_LEVEL = 8'h00;
  localparam logic [7:0] ACCESS_OVERRUN = 8'h46;

  // Offsets of the defining values on a direct read
  localparam logic [15:0] DEF_SIZE = 16'h0001;
  localparam logic [15:0] DEF_RD_LEVEL = 16'h0002;
  localparam logic [15:0] DEF_WR_LEVEL = 16'h0003;
  localparam logic [15:0] DEF_OVERRUN = 16'h0004;

  // ****************************************
  // Field layout and reset values
  // ****************************************
  localparam int POS_W = 40;
  localparam int KEY_LSB = 32;
  localparam int LEVEL_W = 3;
  localparam logic [2:0] LEVEL_PUBLIC = 3'h0;
  localparam logic [2:0] LEVEL_MAX = 3'h4;
  localparam logic [31:0] KEY_L1 = 32'h31313131;
  localparam logic [31:0] KEY_L2 = 32'h32323232;
  localparam logic [31:0] KEY_L3 = 32'h33333333;
  localparam logic [31:0] KEY_L4 = 32'h34343434;

  // Kind of parameter transaction
  typedef enum logic [1:0] {
    KIND_READ = 2'h0,
    KIND_WRITE = 2'h1,
    KIND_DIRECT = 2'h3
  } ppal_kind_e;

  // One parameter transaction from the link
  typedef struct packed {
    ppal_kind_e kind;
    logic [9:0] resIndex;
    logic [15:0] offset;
    logic [63:0] data;
  } ppal_req_s;

  // Answer to one transaction
  typedef struct packed {
    logic [63:0] data;
    logic refused;
  } ppal_resp_s;

endpackage

// file: verif/ppal_core_props.sv
// Checker for the preset and access level handler
`timescale 1ns/10ps
module ppal_core_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Observed ports
  input wire logic reqValid,
  input wire ppal_pkg::ppal_req_s req,
  input wire logic transferReleaseFlag,
  input wire ppal_pkg::ppal_resp_s resp_q,
  input wire logic encoderReset,
  input wire logic [2:0] accessLevel_q
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // Level write that no encoder reset overrides
  wire lvlWr = reqValid && req.kind == ppal_pkg::KIND_WRITE && req.resIndex == 10'h104 && !encoderReset;
  property p_ans; reqValid |=> transferReleaseFlag; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_rst; $rose(nrst) |-> accessLevel_q == 3'h0; endproperty
  a_rst: assert property (p_rst) else $error("level after reset");
  property p_enc; encoderReset |=> accessLevel_q == 3'h0; endproperty
  a_enc: assert property (p_enc) else $error("level after encoder reset");
  property p_hold; !lvlWr && !encoderReset |=> $stable(accessLevel_q); endproperty
  a_hold: assert property (p_hold) else $error("level moved");
  property p_bad; lvlWr && req.data[7:0] == 8'h01 && req.data[63:32] != 32'h31313131
    |=> $stable(accessLevel_q) && resp_q.refused; endproperty
  a_bad: assert property (p_bad) else $error("wrong key taken");
  property p_good; lvlWr && req.data == 64'h3232323200000002 |=> accessLevel_q == 3'h2; endproperty
  a_good: assert property (p_good) else $error("key refused");
  property p_rd; reqValid && req.kind == ppal_pkg::KIND_READ && req.resIndex == 10'h104
    |=> resp_q.data[2:0] == $past(accessLevel_q); endproperty
  a_rd: assert property (p_rd) else $error("level read");
  property p_def; reqValid && req.kind == ppal_pkg::KIND_DIRECT && req.resIndex == 10'h101
    && req.offset == 16'h0004 |=> resp_q.data[7:0] == 8'h64; endproperty
  a_def: assert property (p_def) else $error("overrun value");
  property p_one; !reqValid |=> !transferReleaseFlag; endproperty
  a_one: assert property (p_one) else $error("release flag held");
endmodule
bind ppal_core ppal_core_props u_props (.ref_clk(ref_clk), .nrst(nrst), .reqValid(reqValid), .req(req),
  .transferReleaseFlag(transferReleaseFlag), .resp_q(resp_q), .encoderReset(encoderReset),
  .accessLevel_q(accessLevel_q));

// file: verif/ppal_master_model.sv
// Drive-side master issuing parameter transactions
`timescale 1ns/10ps
module ppal_master_model (
  // Clock
  input wire logic ref_clk,
  // Request to the handler
  output logic reqValid,
  output ppal_pkg::ppal_req_s req
);
  // Idle bus at time zero
  initial begin
    reqValid = 1'b0;
    req = '0;
  end
  // One transaction held across one rising edge, then released
  task automatic send(input ppal_pkg::ppal_req_s r);
    ppal_pkg::ppal_req_s t;
    t = r;
    // Direct reads keep their offset: it selects the defining value
    if (r.resIndex == 10'h104 && r.kind != ppal_pkg::KIND_DIRECT) t.offset = 16'h0000;
    if (r.resIndex == 10'h101) t.data[63:40] = 24'h000000;
    @(negedge ref_clk);
    req <= t;
    reqValid <= 1'b1;
    @(negedge ref_clk);
    reqValid <= 1'b0;
    req.data <= ~t.data; // Released bus shows inverted data; kind, index and offset keep their values
  endtask
endmodule

// file: verif/testbench.sv
// Self-checking bench for the preset and access level handler
`timescale 1ns/10ps
module testbench;
  // ****************************************
  // Signals and rows
  // ****************************************
  localparam ppal_pkg::ppal_kind_e RD = ppal_pkg::KIND_READ;
  localparam ppal_pkg::ppal_kind_e WR = ppal_pkg::KIND_WRITE;
  localparam ppal_pkg::ppal_kind_e DR = ppal_pkg::KIND_DIRECT;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic encoderReset = 1'b0;
  logic [39:0] rawPosition = 40'h0000000010; // Shaft at rest
  logic [39:0] measureRangeMax = 40'h000000ffff;
  logic reqValid, transferReleaseFlag, presetPending_q;
  ppal_pkg::ppal_req_s req;
  ppal_pkg::ppal_resp_s resp_q;
  logic [39:0] position_q;
  logic [2:0] accessLevel_q;
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  typedef struct packed {ppal_pkg::ppal_req_s r; logic f; logic [7:0] v; logic [2:0] l;} ppal_row_s;
  ppal_row_s rows [18];
  function automatic ppal_row_s row(ppal_pkg::ppal_kind_e k, logic [9:0] i, logic [15:0] o, logic [63:0] d,
    logic f, logic [7:0] v, logic [2:0] l);
    return '{'{k, i, o, d}, f, v, l};
  endfunction
  ppal_core dut (.ref_clk(ref_clk), .nrst(nrst), .reqValid(reqValid), .req(req),
    .transferReleaseFlag(transferReleaseFlag), .resp_q(resp_q), .encoderReset(encoderReset),
    .rawPosition(rawPosition), .measureRangeMax(measureRangeMax), .position_q(position_q),
    .accessLevel_q(accessLevel_q), .presetPending_q(presetPending_q));
  ppal_master_model mdl (.ref_clk(ref_clk), .reqValid(reqValid), .req(req));
  // Clock and cycle ceiling
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      close_out();
    end
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("Mismatches %0d, comparisons %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence: rows, then encoder reset and mid-run reset
  initial begin
    rows = '{
      row(RD, 10'h104, 16'h0, 64'h0, 1'h0, 8'h00, 3'h0),
      row(WR, 10'h104, 16'h5, 64'h3232323200000001, 1'h1, 8'h00, 3'h0),
      row(WR, 10'h104, 16'h0, 64'h3131313100000001, 1'h0, 8'h00, 3'h1),
      row(RD, 10'h104, 16'h0, 64'h0, 1'h0, 8'h01, 3'h1),
      row(WR, 10'h104, 16'h0, 64'h3535353500000005, 1'h1, 8'h00, 3'h1),
      row(WR, 10'h101, 16'h0, 64'h100, 1'h1, 8'h00, 3'h1),
      row(WR, 10'h104, 16'h0, 64'h3333333300000003, 1'h0, 8'h00, 3'h3),
      row(WR, 10'h104, 16'h0, 64'h3434343400000004, 1'h0, 8'h00, 3'h4),
      row(WR, 10'h104, 16'h0, 64'h3232323200000002, 1'h0, 8'h00, 3'h2),
      row(DR, 10'h101, 16'h1, 64'h0, 1'h0, 8'h08, 3'h2),
      row(DR, 10'h101, 16'h2, 64'h0, 1'h0, 8'h00, 3'h2),
      row(DR, 10'h101, 16'h3, 64'h0, 1'h0, 8'h02, 3'h2),
      row(DR, 10'h101, 16'h4, 64'h0, 1'h0, 8'h64, 3'h2),
      row(DR, 10'h104, 16'h4, 64'h0, 1'h0, 8'h46, 3'h2),
      row(DR, 10'h104, 16'h3, 64'h0, 1'h0, 8'h00, 3'h2),
      row(WR, 10'h101, 16'h0, 64'h10000, 1'h1, 8'h00, 3'h2),
      row(WR, 10'h101, 16'h0, 64'hffff, 1'h0, 8'h00, 3'h2),
      row(RD, 10'h101, 16'h0, 64'h0, 1'h0, 8'h00, 3'h2)};
    repeat (12) @(negedge ref_clk);
    nrst = 1'b1;
    check(accessLevel_q, 3'h0);
    for (int i = 0; i < 18; i++) begin
      mdl.send(rows[i].r);
      check(transferReleaseFlag, 1'b1);
      check(resp_q.refused, rows[i].f);
      if (rows[i].r.kind != WR) check(resp_q.data[7:0], rows[i].v);
      check(accessLevel_q, rows[i].l);
    end
    check(presetPending_q, 1'b1);
    check(position_q, 40'h0000000010);
    @(negedge ref_clk) encoderReset = 1'b1;
    @(negedge ref_clk) encoderReset = 1'b0;
    @(negedge ref_clk);
    check(position_q, 40'h000000ffff);
    check(accessLevel_q, 3'h0);
    check(presetPending_q, 1'b0);
    check(transferReleaseFlag, 1'b0);
    mdl.send('{RD, 10'h101, 16'h0, 64'h0});
    check(resp_q.data[39:0], 40'h000000ffef);
    mdl.send('{WR, 10'h104, 16'h0, 64'h3131313100000001});
    check(accessLevel_q, 3'h1);
    nrst = 1'b0;
    @(negedge ref_clk) nrst = 1'b1;
    check(accessLevel_q, 3'h0);
    check(position_q, 40'h0000000000);
    close_out();
  end
endmodule
